// ==== rtl/fpsp_host.v ====
// host controller that programs a parallel nor flash and polls its status
`include "fpsp_consts.vh"
module fpsp_host #(
    parameter STROBE_CYC = `FPSP_T_STROBE_CYC,
    parameter RECOV_CYC = `FPSP_T_RECOV_CYC
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output wire o_pslverr,
    // flash pins
    output wire [23:0] o_fl_addr,
    output wire [7:0] o_fl_dq_out,
    output wire o_fl_dq_oe,
    input wire [7:0] i_fl_dq,
    output wire o_fl_ce_n,
    output wire o_fl_oe_n,
    output wire o_fl_we_n,
    output reg o_fl_reset_powerdown_n,
    input wire i_fl_completion_pin
);
    // ***********************************
    // pin synchronisers
    // ***********************************
    reg [7:0] dq_meta_ff;
    reg [7:0] dq_sync_ff;
    reg cpl_meta_ff;
    reg cpl_sync_ff;
    always @(posedge i_clk_sys) begin
        dq_meta_ff <= i_fl_dq;
        dq_sync_ff <= dq_meta_ff;
        cpl_meta_ff <= i_fl_completion_pin;
        cpl_sync_ff <= cpl_meta_ff;
    end
    // ***********************************
    // registers
    // ***********************************
    reg [2:0] op_ff;
    reg use_pin_ff;
    reg [23:0] addr_ff;
    reg [7:0] wdata_ff;
    reg [7:0] rdata_ff;
    reg [7:0] last_sr_ff;
    reg busy_ff;
    reg err_ff;
    reg go_pulse_ff;
    reg rst_req_ff;
    wire wr_en = i_psel && i_penable && i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    wire [7:0] err_mask = (8'h01 << `FPSP_SR_PROG_FAIL) | (8'h01 << `FPSP_SR_SUPPLY) |
        (8'h01 << `FPSP_SR_LOCK);
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            op_ff <= `FPSP_OP_PROGRAM;
            use_pin_ff <= 1'b0;
            addr_ff <= 24'h000000;
            wdata_ff <= 8'h00;
            go_pulse_ff <= 1'b0;
            rst_req_ff <= 1'b0;
        end else begin
            go_pulse_ff <= 1'b0;
            rst_req_ff <= 1'b0;
            if (wr_en) begin
                case (i_paddr)
                    `FPSP_REG_CTRL: begin
                        op_ff <= i_pwdata[`FPSP_CTRL_OP_HI:`FPSP_CTRL_OP_LO];
                        use_pin_ff <= i_pwdata[`FPSP_CTRL_USE_PIN];
                        go_pulse_ff <= i_pwdata[`FPSP_CTRL_GO] & ~busy_ff;
                        rst_req_ff <= i_pwdata[`FPSP_CTRL_RESET] & ~busy_ff;
                    end
                    `FPSP_REG_ADDR: begin
                        addr_ff <= i_pwdata[23:0];
                    end
                    `FPSP_REG_WDATA: begin
                        wdata_ff <= i_pwdata[7:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
    always @* begin
        case (i_paddr)
            `FPSP_REG_CTRL: o_prdata = {26'h0000000, rst_req_ff, use_pin_ff, op_ff, 1'b0};
            `FPSP_REG_ADDR: o_prdata = {8'h00, addr_ff};
            `FPSP_REG_WDATA: o_prdata = {24'h000000, wdata_ff};
            `FPSP_REG_STATUS: o_prdata = {21'h000000, cpl_sync_ff, err_ff, busy_ff,
                last_sr_ff};
            `FPSP_REG_RDATA: o_prdata = {24'h000000, rdata_ff};
            default: o_prdata = 32'h00000000;
        endcase
    end
    // ***********************************
    // sequencer
    // ***********************************
    localparam Q_IDLE = 8'h01;
    localparam Q_SETUP = 8'h02;
    localparam Q_DATA = 8'h04;
    localparam Q_POLL = 8'h08;
    localparam Q_PIN = 8'h10;
    localparam Q_CMD = 8'h20;
    localparam Q_READ = 8'h40;
    localparam Q_RST = 8'h80;
    reg [7:0] st_ff;
    reg cyc_start_ff;
    reg cyc_write_ff;
    reg [23:0] cyc_addr_ff;
    reg [7:0] cyc_wdata_ff;
    reg [7:0] rst_cnt_ff;
    wire cyc_done;
    wire [7:0] cyc_rdata;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_ff <= Q_IDLE;
            busy_ff <= 1'b0;
            err_ff <= 1'b0;
            rdata_ff <= 8'h00;
            last_sr_ff <= 8'h00;
            cyc_start_ff <= 1'b0;
            cyc_write_ff <= 1'b0;
            cyc_addr_ff <= 24'h000000;
            cyc_wdata_ff <= 8'h00;
            rst_cnt_ff <= 8'h00;
            o_fl_reset_powerdown_n <= 1'b0;
        end else begin
            cyc_start_ff <= 1'b0;
            case (st_ff)
                Q_IDLE: begin
                    // device leaves reset in array read, status cleared
                    o_fl_reset_powerdown_n <= 1'b1;
                    if (rst_req_ff) begin
                        busy_ff <= 1'b1;
                        o_fl_reset_powerdown_n <= 1'b0;
                        rst_cnt_ff <= STROBE_CYC[7:0];
                        st_ff <= Q_RST;
                    end else if (go_pulse_ff) begin
                        busy_ff <= 1'b1;
                        cyc_start_ff <= 1'b1;
                        cyc_addr_ff <= addr_ff;
                        cyc_write_ff <= 1'b1;
                        case (op_ff)
                            `FPSP_OP_PROGRAM: begin
                                cyc_wdata_ff <= `FPSP_CMD_PROGRAM_SETUP;
                                st_ff <= Q_SETUP;
                            end
                            `FPSP_OP_CLEAR: begin
                                cyc_wdata_ff <= `FPSP_CMD_CLEAR_STATUS;
                                st_ff <= Q_CMD;
                            end
                            `FPSP_OP_ARRAY: begin
                                cyc_wdata_ff <= `FPSP_CMD_READ_ARRAY;
                                st_ff <= Q_CMD;
                            end
                            `FPSP_OP_STATUS: begin
                                cyc_wdata_ff <= `FPSP_CMD_READ_STATUS;
                                st_ff <= Q_CMD;
                            end
                            `FPSP_OP_QUERY: begin
                                // query mode first, then read at the same address
                                cyc_wdata_ff <= `FPSP_CMD_READ_QUERY;
                                st_ff <= Q_CMD;
                            end
                            default: begin
                                // plain read from the current read mode
                                cyc_write_ff <= 1'b0;
                                st_ff <= Q_READ;
                            end
                        endcase
                    end
                end
                Q_SETUP: begin
                    if (cyc_done) begin
                        cyc_start_ff <= 1'b1;
                        cyc_wdata_ff <= wdata_ff; // same address as setup
                        st_ff <= Q_DATA;
                    end
                end
                Q_DATA: begin
                    if (cyc_done) begin
                        if (use_pin_ff) begin
                            st_ff <= Q_PIN;
                        end else begin
                            // reads now return status
                            cyc_start_ff <= 1'b1;
                            cyc_write_ff <= 1'b0;
                            st_ff <= Q_POLL;
                        end
                    end
                end
                Q_PIN: begin
                    // released pin means done in any read mode
                    if (cpl_sync_ff) begin
                        cyc_start_ff <= 1'b1;
                        cyc_write_ff <= 1'b0;
                        st_ff <= Q_POLL;
                    end
                end
                Q_POLL: begin
                    if (cyc_done) begin
                        last_sr_ff <= cyc_rdata;
                        if (cyc_rdata[`FPSP_SR_READY]) begin
                            // errors accumulate, software may check later
                            err_ff <= err_ff | (|(cyc_rdata & err_mask));
                            busy_ff <= 1'b0;
                            st_ff <= Q_IDLE;
                        end else begin
                            // each new read re-toggles oe to refresh status
                            cyc_start_ff <= 1'b1;
                        end
                    end
                end
                Q_CMD: begin
                    if (cyc_done) begin
                        if (op_ff == `FPSP_OP_CLEAR) begin
                            err_ff <= 1'b0;
                            last_sr_ff <= 8'h00;
                        end
                        if (op_ff == `FPSP_OP_QUERY) begin
                            cyc_start_ff <= 1'b1;
                            cyc_write_ff <= 1'b0;
                            st_ff <= Q_READ;
                        end else begin
                            busy_ff <= 1'b0;
                            st_ff <= Q_IDLE;
                        end
                    end
                end
                Q_READ: begin
                    if (cyc_done) begin
                        // query entries: page 03, burst 00
                        rdata_ff <= cyc_rdata;
                        busy_ff <= 1'b0;
                        st_ff <= Q_IDLE;
                    end
                end
                Q_RST: begin
                    // pulse reset/power-down low
                    if (rst_cnt_ff == 8'h00) begin
                        o_fl_reset_powerdown_n <= 1'b1;
                        err_ff <= 1'b0;
                        last_sr_ff <= 8'h00;
                        busy_ff <= 1'b0;
                        st_ff <= Q_IDLE;
                    end else begin
                        rst_cnt_ff <= rst_cnt_ff - 8'h01;
                    end
                end
                default: begin
                    st_ff <= Q_IDLE;
                end
            endcase
        end
    end
    // ***********************************
    // bus cycle engine
    // ***********************************
    fpsp_bus_cycle #(
        .STROBE_CYC(STROBE_CYC),
        .RECOV_CYC(RECOV_CYC)
    ) u_cycle (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_start(cyc_start_ff),
        .i_write(cyc_write_ff),
        .i_addr(cyc_addr_ff),
        .i_wdata(cyc_wdata_ff),
        .o_done(cyc_done),
        .o_rdata(cyc_rdata),
        .o_fl_addr(o_fl_addr),
        .o_fl_dq_out(o_fl_dq_out),
        .o_fl_dq_oe(o_fl_dq_oe),
        .i_fl_dq_sync(dq_sync_ff),
        .o_fl_ce_n(o_fl_ce_n),
        .o_fl_oe_n(o_fl_oe_n),
        .o_fl_we_n(o_fl_we_n)
    );
endmodule

// ==== rtl/fpsp_consts.vh ====
// constants for the flash program sequencer host controller
`ifndef FPSP_CONSTS_VH
`define FPSP_CONSTS_VH
// flash command codes
`define FPSP_CMD_PROGRAM_SETUP 8'h40
`define FPSP_CMD_READ_ARRAY 8'hff
`define FPSP_CMD_READ_STATUS 8'h70
`define FPSP_CMD_CLEAR_STATUS 8'h50
`define FPSP_CMD_READ_QUERY 8'h98
// flash status bit positions
`define FPSP_SR_READY 7
`define FPSP_SR_PROG_FAIL 4
`define FPSP_SR_SUPPLY 3
`define FPSP_SR_LOCK 1
// query table entries
`define FPSP_QRY_PTR_OFS 8'h15
`define FPSP_QRY_PAGE_REL 8'h13
`define FPSP_QRY_BURST_REL 8'h14
// apb register byte addresses
`define FPSP_REG_CTRL 12'h000
`define FPSP_REG_ADDR 12'h004
`define FPSP_REG_WDATA 12'h008
`define FPSP_REG_STATUS 12'h00c
`define FPSP_REG_RDATA 12'h010
// ctrl register fields
`define FPSP_CTRL_GO 0
`define FPSP_CTRL_OP_LO 1
`define FPSP_CTRL_OP_HI 3
`define FPSP_CTRL_USE_PIN 4
`define FPSP_CTRL_RESET 5
// operation codes
`define FPSP_OP_PROGRAM 3'h0
`define FPSP_OP_CLEAR 3'h1
`define FPSP_OP_ARRAY 3'h2
`define FPSP_OP_READ 3'h3
`define FPSP_OP_STATUS 3'h4
`define FPSP_OP_QUERY 3'h5
// bus timing in ns and derived cycle counts at 125 mhz
`define FPSP_CLK_NS 8
`define FPSP_T_STROBE_NS 70
`define FPSP_T_STROBE_CYC ((`FPSP_T_STROBE_NS + `FPSP_CLK_NS - 1) / `FPSP_CLK_NS)
`define FPSP_T_RECOV_NS 30
`define FPSP_T_RECOV_CYC ((`FPSP_T_RECOV_NS + `FPSP_CLK_NS - 1) / `FPSP_CLK_NS)
`endif

// ==== rtl/fpsp_bus_cycle.v ====
// one asynchronous flash bus cycle: write or read strobe with timing
`include "fpsp_consts.vh"
module fpsp_bus_cycle #(
    parameter STROBE_CYC = `FPSP_T_STROBE_CYC,
    parameter RECOV_CYC = `FPSP_T_RECOV_CYC
) (
    // clock and reset
    input wire i_clk_sys,
    input wire i_reset,
    // request
    input wire i_start,
    input wire i_write,
    input wire [23:0] i_addr,
    input wire [7:0] i_wdata,
    output wire o_done,
    output reg [7:0] o_rdata,
    // flash pins
    output reg [23:0] o_fl_addr,
    output reg [7:0] o_fl_dq_out,
    output reg o_fl_dq_oe,
    input wire [7:0] i_fl_dq_sync,
    output reg o_fl_ce_n,
    output reg o_fl_oe_n,
    output reg o_fl_we_n
);
    // ***********************************
    // strobe sequencer
    // ***********************************
    localparam S_IDLE = 3'b001;
    localparam S_STROBE = 3'b010;
    localparam S_RECOV = 3'b100;
    reg [2:0] state_ff;
    reg [7:0] cnt_ff;
    reg write_ff;
    reg done_ff;
    assign o_done = done_ff;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            state_ff <= S_IDLE;
            cnt_ff <= 8'h00;
            write_ff <= 1'b0;
            done_ff <= 1'b0;
            o_rdata <= 8'h00;
            o_fl_addr <= 24'h000000;
            o_fl_dq_out <= 8'h00;
            o_fl_dq_oe <= 1'b0;
            o_fl_ce_n <= 1'b1;
            o_fl_oe_n <= 1'b1;
            o_fl_we_n <= 1'b1;
        end else begin
            done_ff <= 1'b0;
            case (state_ff)
                S_IDLE: begin
                    if (i_start) begin
                        write_ff <= i_write;
                        o_fl_addr <= i_addr;
                        o_fl_dq_out <= i_wdata;
                        o_fl_dq_oe <= i_write;
                        o_fl_ce_n <= 1'b0;
                        o_fl_we_n <= ~i_write;
                        o_fl_oe_n <= i_write;
                        cnt_ff <= STROBE_CYC[7:0] + 8'h02;
                        state_ff <= S_STROBE;
                    end
                end
                S_STROBE: begin
                    // two extra cycles cover the input synchroniser delay
                    if (cnt_ff == 8'h00) begin
                        if (!write_ff) begin
                            o_rdata <= i_fl_dq_sync;
                        end
                        // oe rising then falling again refreshes status
                        o_fl_we_n <= 1'b1;
                        o_fl_oe_n <= 1'b1;
                        o_fl_ce_n <= 1'b1;
                        cnt_ff <= RECOV_CYC[7:0];
                        state_ff <= S_RECOV;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                S_RECOV: begin
                    o_fl_dq_oe <= 1'b0;
                    if (cnt_ff == 8'h00) begin
                        done_ff <= 1'b1;
                        state_ff <= S_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                end
                default: begin
                    state_ff <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ==== tb/fpsp_host_monitor.sv ====
// port checker for the flash program sequencer host
module fpsp_host_monitor #(
    parameter STROBE_CYC = 9,
    parameter RECOV_CYC = 4
) (
    input wire i_clk_sys,
    input wire i_reset,
    input wire [23:0] o_fl_addr,
    input wire [7:0] o_fl_dq_out,
    input wire o_fl_dq_oe,
    input wire o_fl_ce_n,
    input wire o_fl_oe_n,
    input wire o_fl_we_n,
    input wire o_fl_reset_powerdown_n,
    input wire i_fl_completion_pin
);
    // ****************************************
    // strobe counters and setup tracking
    // ****************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    reg [7:0] lo_cnt_ff;
    reg [7:0] hi_cnt_ff;
    reg setup_ff;
    reg [23:0] setup_addr_ff;
    always @(posedge i_clk_sys) begin
        if (i_reset) begin
            lo_cnt_ff <= 8'h00;
            hi_cnt_ff <= 8'hff;
            setup_ff <= 1'b0;
            setup_addr_ff <= 24'h000000;
        end else begin
            lo_cnt_ff <= o_fl_ce_n ? 8'h00 : lo_cnt_ff + 8'h01;
            hi_cnt_ff <= !o_fl_ce_n ? 8'h00 : (hi_cnt_ff == 8'hff ? hi_cnt_ff : hi_cnt_ff + 8'h01);
            if (!o_fl_we_n && !o_fl_ce_n && lo_cnt_ff == 8'h00) begin
                setup_ff <= !setup_ff && o_fl_dq_out == 8'h40;
                setup_addr_ff <= o_fl_addr;
            end
        end
    end
    wire wr_first = !o_fl_we_n && !o_fl_ce_n && lo_cnt_ff == 8'h00;
    // ****************************************
    // properties
    // ****************************************
    property p_write_drives;
        !o_fl_we_n |-> o_fl_dq_oe && !o_fl_ce_n;
    endproperty
    a_write_drives: assert property (p_write_drives)
        else $error("data bus not driven during write strobe");
    property p_read_no_drive;
        !o_fl_oe_n |-> !o_fl_dq_oe && o_fl_we_n;
    endproperty
    a_read_no_drive: assert property (p_read_no_drive)
        else $error("host drives data bus during read strobe");
    property p_setup_pair;
        wr_first && setup_ff |-> o_fl_addr == setup_addr_ff;
    endproperty
    a_setup_pair: assert property (p_setup_pair)
        else $error("program data write at other address than setup");
    property p_setup_then_write;
        !o_fl_oe_n && !o_fl_ce_n |-> !setup_ff;
    endproperty
    a_setup_then_write: assert property (p_setup_then_write)
        else $error("read issued between setup and data write");
    property p_idle_when_busy;
        wr_first && !setup_ff |-> i_fl_completion_pin;
    endproperty
    a_idle_when_busy: assert property (p_idle_when_busy)
        else $error("command written while device busy");
    property p_strobe_len;
        $rose(o_fl_ce_n) |-> lo_cnt_ff == STROBE_CYC + 3;
    endproperty
    a_strobe_len: assert property (p_strobe_len)
        else $error("strobe length wrong");
    property p_recovery;
        $fell(o_fl_ce_n) |-> hi_cnt_ff >= RECOV_CYC + 1;
    endproperty
    a_recovery: assert property (p_recovery)
        else $error("recovery between bus cycles too short");
    property p_addr_hold;
        !o_fl_ce_n && lo_cnt_ff != 8'h00 |-> $stable(o_fl_addr) && $stable(o_fl_dq_out);
    endproperty
    a_addr_hold: assert property (p_addr_hold)
        else $error("address or data changed inside strobe");
    c_setup_pair: cover property (wr_first && setup_ff);
    c_pd_pulse: cover property ($fell(o_fl_reset_powerdown_n));
    c_pin_release: cover property ($rose(i_fl_completion_pin));
endmodule
bind fpsp_host fpsp_host_monitor #(.STROBE_CYC(STROBE_CYC), .RECOV_CYC(RECOV_CYC)) u_mon (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .o_fl_addr(o_fl_addr),
    .o_fl_dq_out(o_fl_dq_out), .o_fl_dq_oe(o_fl_dq_oe), .o_fl_ce_n(o_fl_ce_n),
    .o_fl_oe_n(o_fl_oe_n), .o_fl_we_n(o_fl_we_n),
    .o_fl_reset_powerdown_n(o_fl_reset_powerdown_n), .i_fl_completion_pin(i_fl_completion_pin)
);

// ==== tb/fpsp_flash_model.sv ====
// behavioural model of the parallel nor flash device
module fpsp_flash_model #(
    parameter BUSY_NS = 1500
) (
    // flash pins
    input wire [23:0] i_addr,
    input wire [7:0] i_dq_in,
    input wire i_ce_n,
    input wire i_oe_n,
    input wire i_we_n,
    input wire i_reset_powerdown_n,
    output wire [7:0] o_dq,
    output wire o_completion_pin,
    // fault injection: bit0 lock, bit1 supply, bit2 program
    input wire [2:0] i_fault
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // command interface and status
    // ****************************************
    reg [7:0] mem_ff [0:255];
    reg [7:0] err_ff = 8'h00;
    reg [1:0] mode_ff = 2'd0;
    reg setup_ff = 1'b0;
    reg busy_ff = 1'b0;
    reg [7:0] snap_ff = 8'h00;
    reg [7:0] last_ff = 8'h00;
    wire wr = ~(i_ce_n | i_we_n);
    wire rd = ~(i_ce_n | i_oe_n);
    wire [7:0] status = {~busy_ff, err_ff[6:0]};
    wire [7:0] rd_val = mode_ff == 2'd0 ? mem_ff[i_addr[7:0]] :
                        (mode_ff == 2'd1 ? snap_ff : qry(i_addr[7:0]));
    integer k;
    initial begin
        for (k = 0; k < 256; k = k + 1) begin
            mem_ff[k] = 8'hff;
        end
    end
    function [7:0] qry(input [7:0] a);
        case (a)
            8'h15: qry = 8'h31;
            8'h44: qry = 8'h03;
            default: qry = 8'h00;
        endcase
    endfunction
    always @(negedge wr or negedge i_reset_powerdown_n) begin
        if (!i_reset_powerdown_n) begin
            err_ff = 8'h00;
            busy_ff = 1'b0;
            mode_ff = 2'd0;
            setup_ff = 1'b0;
        end else if (setup_ff) begin
            setup_ff = 1'b0;
            busy_ff = 1'b1;
            err_ff = err_ff | {3'b000, i_fault[2:1], 1'b0, i_fault[0], 1'b0};
            if (i_fault == 3'b000) begin
                mem_ff[i_addr[7:0]] = i_dq_in;
            end
        end else begin
            case (i_dq_in)
                8'h40: setup_ff = 1'b1;
                8'h50: err_ff = 8'h00;
                8'h70: mode_ff = 2'd1;
                8'h98: mode_ff = 2'd2;
                8'hff: mode_ff = 2'd0;
                default: mode_ff = mode_ff;
            endcase
            mode_ff = setup_ff ? 2'd1 : mode_ff;
        end
    end
    always @(posedge busy_ff) begin
        #(BUSY_NS);
        busy_ff = 1'b0;
    end
    always @(posedge rd) begin
        snap_ff = status;
    end
    always @(negedge rd) begin
        last_ff = rd_val;
    end
    // released bus shows the inverse of the last value
    assign o_dq = rd ? rd_val : ~last_ff;
    assign o_completion_pin = !(busy_ff && i_reset_powerdown_n);
endmodule

// ==== tb/tb_fpsp_host.sv ====
// self-checking testbench for the flash program sequencer host
`include "fpsp_consts.vh"
module tb_fpsp_host;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals and instances
    // ****************************************
    reg clk_sys = 1'b0;
    reg reset = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    reg [2:0] fault = 3'b000;
    reg [31:0] q;
    reg [7:0] exp;
    integer errors = 0;
    integer comparisons = 0;
    integer i;
    wire pready, pslverr, dq_oe, ce_n, oe_n, we_n, rp_n, pin;
    wire [31:0] prdata;
    wire [23:0] fl_addr;
    wire [7:0] dq_out, dev_dq;
    wire [7:0] fl_dq = dq_oe ? dq_out : dev_dq;
    fpsp_host #(.STROBE_CYC(2), .RECOV_CYC(1)) dut (
        .i_clk_sys(clk_sys), .i_reset(reset), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .o_fl_addr(fl_addr), .o_fl_dq_out(dq_out),
        .o_fl_dq_oe(dq_oe), .i_fl_dq(fl_dq), .o_fl_ce_n(ce_n), .o_fl_oe_n(oe_n),
        .o_fl_we_n(we_n), .o_fl_reset_powerdown_n(rp_n), .i_fl_completion_pin(pin));
    fpsp_flash_model #(.BUSY_NS(1500)) flash (
        .i_addr(fl_addr), .i_dq_in(dq_out), .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
        .i_reset_powerdown_n(rp_n), .o_dq(dev_dq), .o_completion_pin(pin), .i_fault(fault));
    initial begin
        forever #4 clk_sys = ~clk_sys;
    end
    // ****************************************
    // tasks
    // ****************************************
    task report_and_stop;
        begin
            if (errors == 0 && comparisons > 0) begin
                $display("verification passed");
            end else begin
                $display("verification failed");
            end
            $finish;
        end
    endtask
    task check(input [31:0] got, input [31:0] want);
        begin
            comparisons = comparisons + 1;
            if (got !== want) begin
                errors = errors + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, want);
            end
        end
    endtask
    task apb(input wr, input [11:0] a, input [31:0] d);
        integer n;
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            n = 0;
            do begin
                @(posedge clk_sys);
                n = n + 1;
            end while (pready !== 1'b1 && n < 50);
            q = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            if (pready !== 1'b1) begin
                check(32'h0, 32'h1);
                report_and_stop;
            end
        end
    endtask
    task wait_idle;
        integer n;
        begin
            repeat (2) @(posedge clk_sys);
            n = 0;
            q = 32'h100;
            while (q[8] !== 1'b0 && n < 2000) begin
                apb(1'b0, `FPSP_REG_STATUS, 32'h0);
                n = n + 1;
            end
            if (q[8] !== 1'b0) begin
                check(q, 32'h0);
                report_and_stop;
            end
        end
    endtask
    task run_op(input [2:0] op, input [23:0] a, input [7:0] d, input use_pin);
        begin
            apb(1'b1, `FPSP_REG_ADDR, {8'h00, a});
            apb(1'b1, `FPSP_REG_WDATA, {24'h0, d});
            apb(1'b1, `FPSP_REG_CTRL, {27'h0, use_pin, op, 1'b1});
            wait_idle;
        end
    endtask
    task rd_data(input [2:0] op, input [23:0] a, input [7:0] want);
        begin
            run_op(op, a, 8'h00, 1'b0);
            apb(1'b0, `FPSP_REG_RDATA, 32'h0);
            check(q, {24'h0, want});
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        apb(1'b0, `FPSP_REG_STATUS, 32'h0);
        check(q, 32'h400);
        apb(1'b1, 12'h020, 32'h5);
        apb(1'b0, 12'h020, 32'h0);
        check(q, 32'h0);
        run_op(`FPSP_OP_PROGRAM, 24'h10, 8'ha5, 1'b0);
        check(q & 32'h3ff, 32'h080);
        run_op(`FPSP_OP_PROGRAM, 24'h11, 8'h3c, 1'b1);
        check(q & 32'h3ff, 32'h080);
        check({24'h0, flash.mem_ff[8'h10]}, 32'ha5);
        run_op(`FPSP_OP_ARRAY, 24'h0, 8'h00, 1'b0);
        rd_data(`FPSP_OP_READ, 24'h11, 8'h3c);
        exp = 8'h80;
        for (i = 0; i < 3; i = i + 1) begin
            fault <= 3'b001 << i;
            run_op(`FPSP_OP_PROGRAM, 24'h20 + i, 8'h5a, 1'b0);
            exp = exp | (i == 0 ? 8'h02 : (i == 1 ? 8'h08 : 8'h10));
            check(q & 32'h3ff, {22'h0, 2'b10, exp});
        end
        fault <= 3'b000;
        run_op(`FPSP_OP_PROGRAM, 24'h23, 8'h66, 1'b0);
        check(q & 32'h3ff, {22'h0, 2'b10, exp});
        check({24'h0, flash.mem_ff[8'h23]}, 32'h66);
        run_op(`FPSP_OP_CLEAR, 24'h0, 8'h00, 1'b0);
        run_op(`FPSP_OP_STATUS, 24'h0, 8'h00, 1'b0);
        check(q & 32'h3ff, 32'h000);
        rd_data(`FPSP_OP_READ, 24'h0, 8'h80);
        rd_data(`FPSP_OP_QUERY, 24'h15, 8'h31);
        rd_data(`FPSP_OP_QUERY, 24'h44, 8'h03);
        rd_data(`FPSP_OP_QUERY, 24'h45, 8'h00);
        apb(1'b1, `FPSP_REG_ADDR, 32'h30);
        apb(1'b1, `FPSP_REG_WDATA, 32'h77);
        apb(1'b1, `FPSP_REG_CTRL, {28'h0, `FPSP_OP_PROGRAM, 1'b1});
        repeat (2) @(posedge clk_sys);
        apb(1'b1, `FPSP_REG_CTRL, {28'h0, `FPSP_OP_ARRAY, 1'b1});
        wait_idle;
        check({30'h0, flash.mode_ff}, 32'h1);
        check({24'h0, flash.mem_ff[8'h30]}, 32'h77);
        fault <= 3'b010;
        run_op(`FPSP_OP_PROGRAM, 24'h31, 8'h11, 1'b0);
        fault <= 3'b000;
        apb(1'b1, `FPSP_REG_CTRL, 32'h20);
        wait_idle;
        check({24'h0, flash.err_ff}, 32'h0);
        rd_data(`FPSP_OP_READ, 24'h10, 8'ha5);
        run_op(`FPSP_OP_STATUS, 24'h0, 8'h00, 1'b0);
        check(q & 32'h3ff, 32'h000);
        rd_data(`FPSP_OP_READ, 24'h0, 8'h80);
        report_and_stop;
    end
endmodule
